/* common/fplg_consts.vh */
`ifndef FPLG_CONSTS_VH
`define FPLG_CONSTS_VH
// ==================================================
// operation codes
`define FPLG_OP_READ 2'h0
`define FPLG_OP_WRITE 2'h1
`define FPLG_OP_ERASE 2'h2
`define FPLG_OP_DEV_ERASE 2'h3
// ==================================================
// requester codes
`define FPLG_SRC_DEBUG 2'h0
`define FPLG_SRC_FW_UNLOCKED 2'h1
`define FPLG_SRC_FW_LOCKED 2'h2
// ==================================================
// verdict codes
`define FPLG_VERDICT_PERMIT 2'h0
`define FPLG_VERDICT_IGNORE 2'h1
`define FPLG_VERDICT_RESET 2'h2
// ==================================================
// lock byte layout and reset values
`define FPLG_LOCK_ERASED 8'hFF
`define FPLG_ZERO_PAGE 4'h0
`endif

/* core/fplg_lock_latch.v */
`timescale 1ns/1ps
`include "fplg_consts.vh"
// ==================================================
// lock state latch: captures the lock byte once per reset
module fplg_lock_latch #(
   parameter NPAGES = 8
) (
   input wire clk,
   input wire srst,
   input wire [NPAGES-1:0] lock_byte,
   output reg [NPAGES-1:0] page_locked_reg,
   output reg any_locked_reg
);
   reg capture_reg;
   // capture on the first edge after reset release; held until next reset
   always @(posedge clk) begin
      if (srst) begin
         capture_reg <= 1'b1;
         page_locked_reg <= {NPAGES{1'b0}};
         any_locked_reg <= 1'b0;
      end else if (capture_reg) begin
         capture_reg <= 1'b0;
         page_locked_reg <= ~lock_byte; // RL17 RL16
         any_locked_reg <= ~(&lock_byte); // RL17
      end
   end
endmodule

/* core/fplg_guard.v */
`timescale 1ns/1ps
`include "fplg_consts.vh"
// Functional notes
// RL1 - Unlocked pages other than the lock-byte page are accessible to every requester.
// RL2 - Locked pages are ignored for debug, reset for unlocked firmware, permitted for locked firmware.
// RL3 - With nothing locked every requester may read or write the lock-byte page.
// RL4 - With any lock, lock-byte page read/write follows ignore, reset, permit by requester.
// RL5 - Reading the lock byte follows the same pattern as lock-byte page reads.
// RL6 - With nothing locked debug may erase the lock-byte page but firmware causes a reset.
// RL7 - With any lock only a debug whole-device erase clears the lock-byte page; firmware resets.
// RL8 - Locking more pages by clearing lock bits is ignored from debug and resets from firmware.
// RL9 - Unlocking pages by setting lock bits is ignored from debug and resets from firmware.
// RL10 - Any access to the reserved area is ignored from debug and resets from firmware.
// RL11 - A debug whole-device erase erases every page and removes all locks.
// RL12 - A prohibited firmware access resets the device and sets the flash error flag.
// RL13 - Prohibited debug operations are silently dropped and never reset the device.
// RL14 - Any locked page makes the lock-byte page locked too.
// RL15 - Once programmed the lock byte changes only through a debug whole-device erase.
// RL16 - A firmware lock-byte write takes effect only after the next reset.
// RL17 - The lock byte is sampled at each reset and held in registers until the next one.
module fplg_guard #(
   parameter NPAGES = 8,
   parameter PAGE_W = 4,
   parameter LOCK_PAGE = 4'h7,
   parameter RSV_PAGE = 4'h8
) (
   input wire clk,
   input wire srst,
   input wire [NPAGES-1:0] lock_byte,
   input wire req_valid,
   input wire [1:0] req_src,
   input wire [1:0] req_op,
   input wire [PAGE_W-1:0] req_page,
   input wire req_lock_byte,
   input wire [NPAGES-1:0] req_wdata,
   input wire flash_error_clear,
   output reg grant_reg,
   output reg ignore_reg,
   output reg dev_erase_reg,
   output reg flash_error_reset_reg,
   output reg flash_error_flag_reg
);
   wire [NPAGES-1:0] page_locked;
   wire any_locked;
   reg [1:0] verdict;
   reg tgt_locked;
   reg denied;
   wire is_debug;
   wire is_fw_locked;
   wire is_lock_page;
   wire is_reserved;
   reg lock_written_reg;
   reg fe_cause_reg;
   // ==================================================
   // lock state captured at reset
   fplg_lock_latch #(.NPAGES(NPAGES)) u_latch (
      .clk(clk),
      .srst(srst),
      .lock_byte(lock_byte),
      .page_locked_reg(page_locked),
      .any_locked_reg(any_locked)
   );
   assign is_debug = (req_src == `FPLG_SRC_DEBUG);
   assign is_fw_locked = (req_src == `FPLG_SRC_FW_LOCKED);
   assign is_lock_page = (req_page == LOCK_PAGE);
   assign is_reserved = (req_page >= RSV_PAGE);
   // ==================================================
   // access decision; denied requests ignore for debug, reset for firmware
   always @* begin
      tgt_locked = 1'b0;
      denied = 1'b0;
      verdict = `FPLG_VERDICT_PERMIT;
      if (!is_reserved && !is_lock_page)
         tgt_locked = page_locked[req_page[2:0]];
      if (req_op == `FPLG_OP_DEV_ERASE) begin
         denied = !is_debug; // RL11
      end else if (is_reserved) begin
         denied = 1'b1; // RL10
      end else if (is_lock_page) begin
         if (req_op == `FPLG_OP_ERASE)
            denied = !is_debug || any_locked; // RL6 RL7
         else if (req_lock_byte && req_op == `FPLG_OP_WRITE)
            denied = lock_written_reg || (req_wdata != lock_byte); // RL8 RL9 RL15
         else
            denied = any_locked && !is_fw_locked; // RL3 RL4 RL5 RL14
      end else begin
         denied = tgt_locked && !is_fw_locked; // RL1 RL2
      end
      if (denied)
         verdict = is_debug ? `FPLG_VERDICT_IGNORE : `FPLG_VERDICT_RESET; // RL13
   end
   // a fresh lock-byte write is tracked so it cannot be changed again before reset or a whole-device erase
   always @(posedge clk) begin
      if (srst)
         lock_written_reg <= 1'b0;
      else if (req_valid && verdict == `FPLG_VERDICT_PERMIT && req_op == `FPLG_OP_DEV_ERASE)
         lock_written_reg <= 1'b0; // RL11
      else if (req_valid && verdict == `FPLG_VERDICT_PERMIT && req_lock_byte && req_op == `FPLG_OP_WRITE)
         lock_written_reg <= 1'b1; // RL15 RL16
   end
   // ==================================================
   // registered verdict outputs, one-cycle pulses
   always @(posedge clk) begin
      if (srst) begin
         grant_reg <= 1'b0;
         ignore_reg <= 1'b0;
         dev_erase_reg <= 1'b0;
         flash_error_reset_reg <= 1'b0;
      end else begin
         grant_reg <= req_valid && (verdict == `FPLG_VERDICT_PERMIT);
         ignore_reg <= req_valid && (verdict == `FPLG_VERDICT_IGNORE); // RL13
         dev_erase_reg <= req_valid && (verdict == `FPLG_VERDICT_PERMIT) && (req_op == `FPLG_OP_DEV_ERASE); // RL11
         flash_error_reset_reg <= req_valid && (verdict == `FPLG_VERDICT_RESET); // RL12
      end
   end
   // remembers that the running reset was caused by a flash error, for as long as srst is held
   always @(posedge clk) begin
      if (flash_error_reset_reg)
         fe_cause_reg <= 1'b1; // RL12
      else if (!srst)
         fe_cause_reg <= 1'b0;
   end
   // error flag survives the device reset it causes; set wins over clear
   always @(posedge clk) begin
      if (req_valid && verdict == `FPLG_VERDICT_RESET)
         flash_error_flag_reg <= 1'b1; // RL12
      else if (flash_error_clear || (srst && !flash_error_reset_reg && !fe_cause_reg))
         flash_error_flag_reg <= 1'b0;
   end
endmodule

/* dv/fplg_flash_model.sv */
`timescale 1ns/1ps
// ==========
// lock byte store in flash, as seen by the guard
module fplg_flash_model (
   input wire clk,
   input wire dev_erase,
   input wire prog_en,
   input wire [7:0] prog_val,
   output reg [7:0] lock_byte
);
   // a whole-device erase wins over programming, leaving every page unlocked
   always @(posedge clk) begin
      if (dev_erase) lock_byte <= 8'hFF;
      else if (prog_en) lock_byte <= prog_val;
   end
endmodule

/* dv/fplg_guard_sva.sv */
`timescale 1ns/1ps
// ==========
// verdict checks at the guard ports
module fplg_guard_chk #(parameter NPAGES = 8, parameter PAGE_W = 4) (
   input wire clk, input wire srst, input wire [NPAGES-1:0] lock_byte, input wire req_valid,
   input wire [1:0] req_src, input wire [1:0] req_op, input wire [PAGE_W-1:0] req_page,
   input wire req_lock_byte, input wire [NPAGES-1:0] req_wdata, input wire flash_error_clear,
   input wire grant_reg, input wire ignore_reg, input wire dev_erase_reg,
   input wire flash_error_reset_reg, input wire flash_error_flag_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // requester classes, used only as antecedents
   wire dbg = req_valid && req_src == 2'h0;
   wire fw = req_valid && req_src != 2'h0;
   one_verdict_a: assert property (req_valid |=> $onehot({grant_reg, ignore_reg, flash_error_reset_reg}))
      else $error("not one verdict");
   quiet_idle_a: assert property (!req_valid |=> !(grant_reg || ignore_reg || flash_error_reset_reg))
      else $error("verdict without request");
   debug_no_reset_a: assert property (dbg |=> !flash_error_reset_reg)
      else $error("debug caused reset");
   fw_no_ignore_a: assert property (fw |=> !ignore_reg)
      else $error("firmware ignored");
   rsv_deny_a: assert property (req_valid && req_page >= 4'h8 |=> !grant_reg)
      else $error("reserved granted");
   dev_erase_a: assert property (dbg && req_op == 2'h3 |=> grant_reg && dev_erase_reg)
      else $error("device erase missed");
   fw_erase_lb_a: assert property (fw && req_op == 2'h2 && req_page == 4'h7 |=> flash_error_reset_reg)
      else $error("firmware lock page erase");
   flag_set_a: assert property (flash_error_reset_reg |=> flash_error_flag_reg)
      else $error("flag not set");
endmodule
bind fplg_guard fplg_guard_chk #(.NPAGES(NPAGES), .PAGE_W(PAGE_W)) fplg_guard_chk_inst (.*);

/* dv/test_flash_page_lock_guard.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t %h", $time, a); end end
module test_flash_page_lock_guard;
   localparam D = 2'h0, U = 2'h1, L = 2'h2, G = 3'h4, I = 3'h2, R = 3'h1;
   reg clk = 0, srst = 1, req_valid = 0, req_lock_byte = 0, flash_error_clear = 1, prog_en = 1;
   reg [1:0] req_src = 0, req_op = 0;
   reg [3:0] req_page = 0;
   reg [7:0] req_wdata = 0, prog_val = 8'hFF;
   wire [7:0] lock_byte;
   wire grant_reg, ignore_reg, dev_erase_reg, flash_error_reset_reg, flash_error_flag_reg;
   int bad_count = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   fplg_guard fplg_guard_inst (.clk(clk), .srst(srst), .lock_byte(lock_byte), .req_valid(req_valid),
      .req_src(req_src), .req_op(req_op), .req_page(req_page), .req_lock_byte(req_lock_byte),
      .req_wdata(req_wdata), .flash_error_clear(flash_error_clear), .grant_reg(grant_reg),
      .ignore_reg(ignore_reg), .dev_erase_reg(dev_erase_reg), .flash_error_reset_reg(flash_error_reset_reg),
      .flash_error_flag_reg(flash_error_flag_reg));
   fplg_flash_model fplg_flash_model_inst (.clk(clk), .dev_erase(dev_erase_reg), .prog_en(prog_en),
      .prog_val(prog_val), .lock_byte(lock_byte));
   // one request, verdict judged in the cycle it stands
   task automatic req(input [1:0] s, input [1:0] o, input [3:0] p, input b, input [7:0] w, input [2:0] v);
      @(negedge clk);
      {req_src, req_op, req_page, req_lock_byte, req_wdata, req_valid} = {s, o, p, b, w, 1'b1};
      @(negedge clk);
      `CHK({grant_reg, ignore_reg, flash_error_reset_reg}, v)
      req_valid = 0;
   endtask
   // reset with a new lock byte; lock is latched on the first edge after release
   task automatic restart(input [7:0] b);
      {prog_en, prog_val, srst} = {1'b1, b, 1'b1};
      repeat (2) @(negedge clk);
      {prog_en, srst} = 2'b00;
      @(negedge clk);
   endtask
   task automatic t_open;
      restart(8'hFF);
      req(U, 1, 4'h3, 0, 0, G);
      req(D, 0, 4'h7, 0, 0, G);
      req(U, 0, 4'h7, 1, 0, G);
      req(D, 2, 4'h7, 0, 0, G);
      req(L, 2, 4'h7, 0, 0, R);
   endtask
   task automatic t_locked;
      restart(8'hF7);
      req(D, 0, 4'h3, 0, 0, I);
      req(U, 0, 4'h3, 0, 0, R);
      req(L, 1, 4'h3, 0, 0, G);
      req(U, 0, 4'h5, 0, 0, G);
      req(D, 1, 4'h7, 0, 0, I);
      req(L, 1, 4'h7, 0, 0, G);
      req(D, 0, 4'h7, 1, 0, I);
      req(D, 2, 4'h7, 0, 0, I);
      req(U, 1, 4'h7, 1, 8'hF3, R);
      req(D, 1, 4'h7, 1, 8'hFF, I);
      req(D, 0, 4'h8, 0, 0, I);
      req(L, 0, 4'h9, 0, 0, R);
   endtask
   // flag survives the reset that follows an error, then clears on request
   task automatic t_flag;
      restart(8'hF7);
      `CHK(flash_error_flag_reg, 1'b1)
      flash_error_clear = 1;
      @(negedge clk);
      flash_error_clear = 0;
      `CHK(flash_error_flag_reg, 1'b0)
   endtask
   task automatic t_erase;
      req(D, 3, 4'h0, 0, 0, G);
      `CHK(dev_erase_reg, 1'b1)
      // plain reset with no programming: only the erase can have unlocked page 3
      srst = 1;
      repeat (2) @(negedge clk);
      srst = 0;
      @(negedge clk);
      req(D, 0, 4'h3, 0, 0, G);
   endtask
   task give_verdict;
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence after the opening reset
   initial begin
      repeat (6) @(negedge clk);
      {srst, prog_en, flash_error_clear} = 3'b000;
      t_open;
      t_locked;
      t_flag;
      t_erase;
      give_verdict;
   end
   // watchdog: whole run takes well under 100 cycles
   initial begin
      #3000;
      bad_count++;
      give_verdict;
   end
endmodule
